// *** core/sld_pkg.sv ***
// ==========================================================
// supply level detector shared definitions
// ==========================================================
package sld_pkg;

	// ==========================================================
	// timing
	// ==========================================================
	// system clock rate in MHz
	localparam int unsigned CLK_MHZ = 10;
	// typical measurement settling time
	localparam int unsigned MEAS_TIME_US = 2000;
	// longest allowed measurement settling time
	localparam int unsigned MEAS_MAX_US = 2500;
	// typical shortest supply dip that is caught
	localparam int unsigned DIP_TIME_US = 875;
	// longest shortest-dip figure
	localparam int unsigned DIP_MAX_US = 1350;
	// settling time in clock cycles
	localparam int unsigned MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;
	// dip filter time in clock cycles
	localparam int unsigned DIP_CYCLES = DIP_TIME_US * CLK_MHZ;
	// width of the interval counters
	localparam int unsigned CNT_W = 16;

	// ==========================================================
	// register map (APB byte addresses)
	// ==========================================================
	localparam int unsigned ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_IRQ = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h00C;

	// ==========================================================
	// field positions and reset values
	// ==========================================================
	localparam int unsigned CTRL_TRIM_LSB = 0;
	localparam int unsigned CTRL_RANGE_BIT = 3;
	localparam int unsigned STAT_EN_BIT = 0;
	localparam int unsigned STAT_VALID_BIT = 1;
	localparam int unsigned STAT_RESULT_BIT = 2;
	localparam int unsigned IRQ_LOW_BIT = 0;
	localparam int unsigned MID_REQ_BIT = 2;
	localparam int unsigned MID_REQ_W = 8;
	localparam logic RANGE_RST = 1'h0;
	localparam logic [2:0] TRIM_RST = 3'h0;
	localparam logic EN_RST = 1'h0;
	localparam logic IRQ_RST = 1'h0;
	localparam logic MASK_RST = 1'h0;

	// ==========================================================
	// types
	// ==========================================================
	typedef logic [CNT_W-1:0] sld_cnt_t;

	// threshold selection carried as one bundle
	typedef struct packed {
		logic range_sel;
		logic [2:0] trim;
	} sld_ctrl_s;

	// detector sequence, gray coded along off, settle, run
	typedef enum logic [1:0] {
		ST_OFF = 2'h0,
		ST_SETTLE = 2'h1,
		ST_RUN = 2'h3
	} sld_state_e;

	// decoded register
	typedef enum logic [2:0] {
		REG_CTRL = 3'h0,
		REG_STAT = 3'h1,
		REG_IRQ = 3'h2,
		REG_MASK = 3'h3,
		REG_NONE = 3'h7
	} sld_reg_e;

endpackage : sld_pkg

// *** core/sld_timer.sv ***
`timescale 1ns/1ps
// ==========================================================
// interval timer: done after LIMIT edges with run high
// ==========================================================
module sld_timer import sld_pkg::*; #(
	parameter sld_cnt_t LIMIT = 16'h0001
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic run, // count while high, clear when low
	output logic done // high once the interval has passed
);

	sld_cnt_t cnt_r;
	sld_cnt_t cnt_nxt;
	logic done_r;
	logic done_nxt;

	// count up and saturate one short of the limit
	always_comb begin
		cnt_nxt = '0;
		done_nxt = 1'b0;
		if (run) begin
			cnt_nxt = (cnt_r == LIMIT - 16'h0001) ? cnt_r : cnt_r + 16'h0001;
			done_nxt = (cnt_r == LIMIT - 16'h0001);
		end
	end

	// register count and done
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;

endmodule : sld_timer

// *** core/sld_top.sv ***
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - control bit 3 selects threshold range
// - control bits 2:0 trim threshold, eight steps
// - status bit 0 enables detector, starts measurement
// - disabled detector is powered down, silent
// - status bit 2 reads supply-below-threshold result
// - status bit 1 reads result valid
// - valid sets after measurement time elapses
// - interrupt events raised only while valid and enabled
// - one interrupt event per result rise
// - interrupt drives middle priority request bit 2
// - supply dips shorter than filter are ignored
module sld_top import sld_pkg::*; #(
	parameter int unsigned MEAS_CYC = MEAS_CYCLES, // settling time in cycles
	parameter int unsigned DIP_CYC = DIP_CYCLES // dip filter time in cycles
) (
	input wire logic REF_CLK, // system clock, 10 MHz
	input wire logic SYS_RST, // synchronous reset, high
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb enable
	input wire logic PWRITE, // apb direction
	input wire logic [ADDR_W-1:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	input wire logic COMP_BELOW, // analog comparator: supply below threshold
	output logic DET_POWER_ON, // powers the analog detector
	output logic THR_RANGE, // threshold range to analog side
	output logic [2:0] THR_TRIM, // threshold trim to analog side
	output logic LOW_SUPPLY_IRQ, // level interrupt, high while unmasked event
	output logic [MID_REQ_W-1:0] MID_PRIORITY_REQ // request lines to interrupt manager
);

	// ==========================================================
	// address decode
	// ==========================================================
	function automatic sld_reg_e reg_sel(input logic [ADDR_W-1:0] addr);
		case (addr)
			ADDR_CTRL: reg_sel = REG_CTRL;
			ADDR_STAT: reg_sel = REG_STAT;
			ADDR_IRQ: reg_sel = REG_IRQ;
			ADDR_MASK: reg_sel = REG_MASK;
			default: reg_sel = REG_NONE;
		endcase
	endfunction : reg_sel

	logic apb_setup;
	logic apb_access;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_irq;
	logic wr_mask;

	// zero wait state slave; writes land at the access edge
	assign apb_setup = PSEL && !PENABLE;
	assign apb_access = PSEL && PENABLE;
	assign PREADY = 1'b1;
	assign PSLVERR = apb_access && (reg_sel(PADDR) == REG_NONE);
	assign wr_ctrl = apb_access && PWRITE && (reg_sel(PADDR) == REG_CTRL);
	assign wr_stat = apb_access && PWRITE && (reg_sel(PADDR) == REG_STAT);
	assign wr_irq = apb_access && PWRITE && (reg_sel(PADDR) == REG_IRQ);
	assign wr_mask = apb_access && PWRITE && (reg_sel(PADDR) == REG_MASK);

	// ==========================================================
	// software registers
	// ==========================================================
	sld_ctrl_s ctrl_r;
	sld_ctrl_s ctrl_nxt;
	logic enable_r;
	logic enable_nxt;
	logic mask_r;
	logic mask_nxt;

	// control, enable and mask updates; reserved bits are dropped
	always_comb begin
		ctrl_nxt = ctrl_r;
		enable_nxt = enable_r;
		mask_nxt = mask_r;
		if (wr_ctrl) begin
			ctrl_nxt.range_sel = PWDATA[CTRL_RANGE_BIT];
			ctrl_nxt.trim = PWDATA[CTRL_TRIM_LSB +: 3];
		end
		if (wr_stat) begin
			enable_nxt = PWDATA[STAT_EN_BIT];
		end
		if (wr_mask) begin
			mask_nxt = PWDATA[IRQ_LOW_BIT];
		end
	end

	// register software state
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ctrl_r.range_sel <= RANGE_RST;
			ctrl_r.trim <= TRIM_RST;
			enable_r <= EN_RST;
			mask_r <= MASK_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			enable_r <= enable_nxt;
			mask_r <= mask_nxt;
		end
	end

	// ==========================================================
	// measurement sequence
	// ==========================================================
	sld_state_e state_r;
	sld_state_e state_nxt;
	logic meas_done;
	logic dip_done;
	logic stat_valid;

	// off until enabled, settle for the measurement time, then run
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: begin
				if (enable_r) state_nxt = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (meas_done) state_nxt = ST_RUN;
			end
			ST_RUN: begin
				state_nxt = ST_RUN;
			end
			default: begin
				state_nxt = ST_OFF;
			end
		endcase
		if (!enable_r) state_nxt = ST_OFF;
	end

	// register sequence state
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) state_r <= ST_OFF;
		else state_r <= state_nxt;
	end

	assign stat_valid = (state_r == ST_RUN) && enable_r;

	// settling interval timer
	sld_timer #(
		.LIMIT(sld_cnt_t'(MEAS_CYC))
	) u_meas_timer (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.run(state_r == ST_SETTLE),
		.done(meas_done)
	);

	// dip filter: the comparator must hold for the filter time
	sld_timer #(
		.LIMIT(sld_cnt_t'(DIP_CYC))
	) u_dip_timer (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.run(stat_valid && COMP_BELOW),
		.done(dip_done)
	);

	// ==========================================================
	// result and interrupt event
	// ==========================================================
	logic result_r;
	logic result_nxt;
	logic irq_r;
	logic irq_nxt;
	logic result_rise;

	// result sets after a filtered dip and clears as soon as supply recovers
	always_comb begin
		result_nxt = 1'b0;
		if (stat_valid) begin
			result_nxt = result_r ? COMP_BELOW : dip_done;
		end
		result_rise = result_nxt && !result_r;
		// a new event wins over a clear written in the same cycle
		irq_nxt = (irq_r && !(wr_irq && PWDATA[IRQ_LOW_BIT])) || result_rise;
	end

	// register result and sticky event flag
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			result_r <= 1'b0;
			irq_r <= IRQ_RST;
		end else begin
			result_r <= result_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ==========================================================
	// read data
	// ==========================================================
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	// capture read data in the setup cycle; reserved bits read zero
	always_comb begin
		prdata_nxt = prdata_r;
		if (apb_setup && !PWRITE) begin
			prdata_nxt = '0;
			case (reg_sel(PADDR))
				REG_CTRL: begin
					prdata_nxt[CTRL_RANGE_BIT] = ctrl_r.range_sel;
					prdata_nxt[CTRL_TRIM_LSB +: 3] = ctrl_r.trim;
				end
				REG_STAT: begin
					prdata_nxt[STAT_EN_BIT] = enable_r;
					prdata_nxt[STAT_VALID_BIT] = stat_valid;
					prdata_nxt[STAT_RESULT_BIT] = result_r;
				end
				REG_IRQ: prdata_nxt[IRQ_LOW_BIT] = irq_r;
				REG_MASK: prdata_nxt[IRQ_LOW_BIT] = mask_r;
				default: prdata_nxt = '0;
			endcase
		end
	end

	// register read data
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) prdata_r <= '0;
		else prdata_r <= prdata_nxt;
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign PRDATA = prdata_r;
	assign DET_POWER_ON = enable_r;
	assign THR_RANGE = ctrl_r.range_sel;
	assign THR_TRIM = ctrl_r.trim;
	assign LOW_SUPPLY_IRQ = irq_r && mask_r;

	// place the interrupt on its request line, others idle
	generate
		for (genvar i = 0; i < MID_REQ_W; i++) begin : g_mid
			if (i == MID_REQ_BIT) begin : g_hit
				assign MID_PRIORITY_REQ[i] = LOW_SUPPLY_IRQ;
			end else begin : g_idle
				assign MID_PRIORITY_REQ[i] = 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// checks
	// ==========================================================
	logic [31:0] settle_cnt_r;
	logic [31:0] dip_cnt_r;

	// cycle counters seen only by the checks
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			settle_cnt_r <= '0;
			dip_cnt_r <= '0;
		end else begin
			settle_cnt_r <= (state_r == ST_SETTLE) ? settle_cnt_r + 32'h1 : 32'h0;
			dip_cnt_r <= (stat_valid && COMP_BELOW) ? dip_cnt_r + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	a_range_write: assert property (wr_ctrl |=> THR_RANGE == $past(PWDATA[3]))
		else $error("range bit did not follow write");
	a_trim_write: assert property (wr_ctrl |=> THR_TRIM == $past(PWDATA[2:0]))
		else $error("trim field did not follow write");
	a_enable_start: assert property (wr_stat && PWDATA[0] && !enable_r |=> ##1 state_r == ST_SETTLE)
		else $error("enable did not start a measurement");
	a_off_quiet: assert property (!enable_r |=> !result_r && !stat_valid && !DET_POWER_ON || enable_r)
		else $error("disabled detector still active");
	a_result_read: assert property (
		apb_setup && !PWRITE && PADDR == ADDR_STAT
		|=> PRDATA[2] == $past(result_r) && PRDATA[1] == $past(stat_valid))
		else $error("status read mismatch");
	a_rsv_status: assert property (
		apb_setup && !PWRITE && PADDR == ADDR_STAT |=> PRDATA[31:3] == 29'h0)
		else $error("reserved status bits not zero");
	a_valid_time: assert property ($rose(stat_valid) |-> $past(settle_cnt_r) == MEAS_CYC)
		else $error("valid set at wrong time");
	a_settle_bound: assert property (state_r == ST_SETTLE |-> settle_cnt_r <= MEAS_CYC)
		else $error("settling ran past measurement time");
	a_off_no_event: assert property (!enable_r && !$past(enable_r) |-> !$rose(irq_r))
		else $error("event while detector disabled");
	a_irq_valid: assert property ($rose(irq_r) |-> $past(stat_valid))
		else $error("interrupt event without valid result");
	a_irq_rise: assert property ($rose(result_r) |-> irq_r)
		else $error("result rise gave no event");
	a_fall_quiet: assert property ($rose(irq_r) |-> $rose(result_r))
		else $error("event without a result rise");
	a_mid_bit: assert property (MID_PRIORITY_REQ == (8'(irq_r && mask_r) << MID_REQ_BIT))
		else $error("request line mapping wrong");
	a_dip_min: assert property ($rose(result_r) |-> $past(dip_cnt_r) == DIP_CYC)
		else $error("dip accepted at wrong length");
	a_rsv_read: assert property (
		apb_setup && !PWRITE && PADDR == ADDR_CTRL |=> PRDATA[31:4] == 28'h0)
		else $error("reserved control bits not zero");

endmodule : sld_top

// *** core/sld_timer_dummy_guard.sv ***
`timescale 1ns/1ps

// *** tb/sld_top_tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// supply level detector bench
// ==========================================================
module sld_top_tb;
	import sld_pkg::*;

	localparam int unsigned MEAS = 20; // shortened settling time
	localparam int unsigned DIP = 8; // shortened dip filter
	localparam int unsigned LIMIT = 6000; // cycle ceiling for the whole run

	logic clk;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic comp_below;
	logic det_power_on;
	logic thr_range;
	logic [2:0] thr_trim;
	logic low_supply_irq;
	logic [MID_REQ_W-1:0] mid_req;
	logic [31:0] rd;
	logic err;
	int miscompares;
	int checks;
	int cycles;

	sld_top #(.MEAS_CYC(MEAS), .DIP_CYC(DIP)) i_dut (
		.REF_CLK(clk),
		.SYS_RST(rst),
		.PSEL(psel),
		.PENABLE(penable),
		.PWRITE(pwrite),
		.PADDR(paddr),
		.PWDATA(pwdata),
		.PRDATA(prdata),
		.PREADY(pready),
		.PSLVERR(pslverr),
		.COMP_BELOW(comp_below),
		.DET_POWER_ON(det_power_on),
		.THR_RANGE(thr_range),
		.THR_TRIM(thr_trim),
		.LOW_SUPPLY_IRQ(low_supply_irq),
		.MID_PRIORITY_REQ(mid_req)
	);

	// ==========================================================
	// clock and hang guard
	// ==========================================================
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// cuts a hung run short
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			final_report();
		end
	end

	// ==========================================================
	// helpers
	// ==========================================================
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cyc

	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rd_chk

	task automatic final_report();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		comp_below = 1'b1;
		miscompares = 0;
		checks = 0;
		cycles = 0;
		wait_cyc(4);
		rst <= 1'b0;

		// reset values, supply already low while disabled
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_STAT, 32'h0);
		rd_chk(ADDR_IRQ, 32'h0);
		rd_chk(ADDR_MASK, 32'h0);
		check(pready, 1'b1);
		$display("test reset done");

		// every range and trim code reaches the analog side
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, ADDR_CTRL, 32'hFFFFFFF0 | i);
			rd_chk(ADDR_CTRL, i);
			check({thr_range, thr_trim}, i);
		end
		apb(1'b1, ADDR_STAT, 32'hFFFFFFFE);
		rd_chk(ADDR_STAT, 32'h0);
		check(det_power_on, 1'b0);
		apb(1'b0, 12'h010, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		check(err, 1'b1);
		rd_chk(ADDR_CTRL, 32'hF);
		$display("test registers done");

		// settling: valid only after the measurement time
		comp_below <= 1'b0;
		apb(1'b1, ADDR_MASK, 32'h1);
		apb(1'b1, ADDR_STAT, 32'h1);
		wait_cyc(MEAS - 4);
		check(det_power_on, 1'b1);
		rd_chk(ADDR_STAT, 32'h1);
		wait_cyc(4);
		rd_chk(ADDR_STAT, 32'h3);
		$display("test settling done");

		// a dip one cycle short of the filter is ignored
		comp_below <= 1'b1;
		wait_cyc(DIP - 1);
		comp_below <= 1'b0;
		wait_cyc(2);
		rd_chk(ADDR_STAT, 32'h3);
		check(low_supply_irq, 1'b0);
		comp_below <= 1'b1;
		wait_cyc(DIP + 4);
		rd_chk(ADDR_STAT, 32'h7);
		rd_chk(ADDR_IRQ, 32'h1);
		check(low_supply_irq, 1'b1);
		check(mid_req, 8'h04);
		$display("test dip done");

		// no new event while the result stays high or falls
		apb(1'b1, ADDR_IRQ, 32'h1);
		wait_cyc(3);
		rd_chk(ADDR_IRQ, 32'h0);
		check(mid_req, 8'h00);
		comp_below <= 1'b0;
		wait_cyc(3);
		rd_chk(ADDR_STAT, 32'h3);
		rd_chk(ADDR_IRQ, 32'h0);
		$display("test edges done");

		// masked event still latches, unmasking raises the line
		apb(1'b1, ADDR_MASK, 32'h0);
		comp_below <= 1'b1;
		wait_cyc(DIP + 4);
		rd_chk(ADDR_IRQ, 32'h1);
		check(low_supply_irq, 1'b0);
		apb(1'b1, ADDR_MASK, 32'h1);
		@(posedge clk);
		check(low_supply_irq, 1'b1);
		check(mid_req, 8'h04);
		$display("test mask done");

		// disabling drops valid and result and silences events
		apb(1'b1, ADDR_STAT, 32'h0);
		apb(1'b1, ADDR_IRQ, 32'h1);
		check(det_power_on, 1'b0);
		rd_chk(ADDR_STAT, 32'h0);
		wait_cyc(DIP + 4);
		rd_chk(ADDR_IRQ, 32'h0);
		check(low_supply_irq, 1'b0);
		$display("test disable done");

		// re-enable with supply low: settle again, then one event
		apb(1'b1, ADDR_STAT, 32'h1);
		wait_cyc(MEAS - 4);
		rd_chk(ADDR_STAT, 32'h1);
		wait_cyc(MEAS);
		rd_chk(ADDR_STAT, 32'h7);
		rd_chk(ADDR_IRQ, 32'h1);
		$display("test restart done");

		// a mid-run reset clears every register and silences the outputs
		rst <= 1'b1;
		wait_cyc(2);
		rst <= 1'b0;
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_STAT, 32'h0);
		rd_chk(ADDR_IRQ, 32'h0);
		rd_chk(ADDR_MASK, 32'h0);
		check(det_power_on, 1'b0);
		check({thr_range, thr_trim}, 32'h0);
		check(low_supply_irq, 1'b0);
		$display("test mid reset done");
		final_report();
	end

endmodule : sld_top_tb
